/* File: rtl/dst_debug_trace.sv */
// Summary of operation
// - arming enters state1, or final with force bit; flags follow state
// - final state only returns to state0
// - force-trigger write triggers immediately
// - per-channel breakpoint enable, independent of sequencer
// - session end passes final one cycle, except begin-aligned tracing holds final until filled
// - final issues trigger; no trace disarms
// - tracing done disarms, may breakpoint
// - trace RAM 64 lines of 20 bits
// - pointer advances after low-half read
// - line count increments every store up to 64, then holds
// - no storing while background debug active
// - armed read invalid, pointer held
// - end alignment traces state1 to final
// - storing starts second cycle after write
// - begin alignment stores 64 then disarms, breakpoint if enabled
// - begin channel-trigger change of flow recorded
// - end alignment stops, skips trigger, wraps
// - four modes, trace source enables recording
// - normal mode records change-of-flow addresses
// - entry holds 18-bit address plus flags
// - destination recorded on instruction completion
// - loop1 drops consecutive duplicate sources
// - trigger, then final channel, then lowest
// - source flag 0, destination flag 1
`timescale 1ns/1ps
module dst_debug_trace #(
   parameter int TRACE_DEPTH = dst_pkg::TRACE_LINES
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          reset_i,
   input  wire logic [dst_pkg::ADDR_W-1:0]    reg_addr_i,
   input  wire logic [dst_pkg::DATA_W-1:0]    reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [dst_pkg::DATA_W-1:0]    reg_rdata_o,
   input  wire logic [dst_pkg::CHANNELS-1:0]  match_i,
   input  wire logic                          bgnd_active_i,
   input  wire logic                          flow_valid_i,
   input  wire logic [dst_pkg::ADDR_BITS-1:0] flow_addr_i,
   input  wire logic                          flow_dest_i,
   input  wire logic                          flow_vector_i,
   input  wire logic                          flow_bgnd_vector_i,
   output logic                               breakpoint_o,
   output logic                               armed_o,
   output logic      [2:0]                    state_flags_o
);
   import dst_pkg::*;

   localparam int PTR_W = $clog2(TRACE_DEPTH);
   localparam int CNT_W = PTR_W + 1;
   localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(TRACE_DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR  = PTR_W'(TRACE_DEPTH - 1);

   typedef struct packed {
      dst_state_type                   state;
      logic [2:0]                      flags;
      logic                            arm;
      logic                            go;
      logic                            bp_en;
      logic                            tsrc;
      logic [1:0]                      mode;
      logic                            align;
      logic [2:0][5:0]                 sc;
      logic [CHANNELS-1:0]             ch_bp;
      logic [PTR_W-1:0]                wr_ptr;
      logic [PTR_W-1:0]                rd_ptr;
      logic [CNT_W-1:0]                count;
      logic                            full;
      logic [ADDR_BITS-1:0]            bg_addr;
      logic                            bg_valid;
      logic [DATA_W-1:0]               rdata;
      logic                            bkpt;
   } dst_regs_type;

   dst_regs_type                s_reg;
   dst_regs_type                s_next;
   logic [LINE_W-1:0]           trace_mem [TRACE_DEPTH];
   logic [LINE_W-1:0]           rd_line;
   logic [LINE_W-1:0]           store_line;
   logic                        ctrl_wr;
   logic                        force_wr;
   logic                        arm_set_wr;
   logic [CHANNELS-1:0]         seq_match;
   logic [5:0]                  sc_cur;
   logic                        win_valid;
   logic [1:0]                  win_code;
   logic                        to_final;
   logic                        entering_final;
   logic                        begin_trace;
   logic                        flow_ok;
   logic                        dup_src;
   logic                        store_window;
   logic                        store_en;

   function automatic dst_state_type code_to_state(input logic [1:0] code);
      case (code)
         NXT_ONE:   code_to_state = ST_ONE;
         NXT_TWO:   code_to_state = ST_TWO;
         NXT_THREE: code_to_state = ST_THREE;
         default:   code_to_state = ST_FINAL;
      endcase
   endfunction

   function automatic logic [2:0] state_to_flags(input dst_state_type st);
      case (st)
         ST_ONE:   state_to_flags = FLAGS_ONE;
         ST_TWO:   state_to_flags = FLAGS_TWO;
         ST_THREE: state_to_flags = FLAGS_THREE;
         ST_FINAL: state_to_flags = FLAGS_FINAL;
         default:  state_to_flags = FLAGS_OFF;
      endcase
   endfunction

   assign rd_line = trace_mem[s_reg.rd_ptr];

   always_comb begin
      s_next      = s_reg;
      s_next.bkpt = 1'b0;
      s_next.rdata = '0;
      ctrl_wr     = reg_wr_i && (reg_addr_i == OFF_CTRL1);
      force_wr    = ctrl_wr && reg_wdata_i[FORCE_BIT] && reg_wdata_i[ARM_BIT];
      arm_set_wr  = ctrl_wr && reg_wdata_i[ARM_BIT];
      begin_trace = s_reg.tsrc && (s_reg.align == ALIGN_BEGIN);
      seq_match   = match_i & ~s_reg.ch_bp;
      case (s_reg.state)
         ST_TWO:   sc_cur = s_reg.sc[1];
         ST_THREE: sc_cur = s_reg.sc[2];
         default:  sc_cur = s_reg.sc[0];
      endcase
      // lowest channel wins, final-bound channel overrides
      win_valid = 1'b0;
      win_code  = NXT_ONE;
      to_final  = 1'b0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         if (seq_match[i]) begin
            win_valid = 1'b1;
            win_code  = sc_cur[2*i +: 2];
         end
      end
      for (int i = 0; i < CHANNELS; i++) begin
         if (seq_match[i] && (sc_cur[2*i +: 2] == NXT_FINAL)) begin
            to_final = 1'b1;
         end
      end

      case (s_reg.state)
         ST_OFF: begin
            if (arm_set_wr) begin
               s_next.arm      = 1'b1;
               s_next.state    = reg_wdata_i[FORCE_BIT] ? ST_FINAL : ST_ONE;
               s_next.wr_ptr   = '0;
               s_next.count    = '0;
               s_next.full     = 1'b0;
               s_next.bg_valid = 1'b0;
            end
         end
         ST_ONE, ST_TWO, ST_THREE: begin
            if (force_wr || to_final) begin
               s_next.state = ST_FINAL;
            end else if (win_valid) begin
               s_next.state = code_to_state(win_code);
            end
         end
         ST_FINAL: begin
            // begin alignment holds armed until buffer filled
            if (begin_trace && (s_reg.count < DEPTH_CNT)) begin
               s_next.state = ST_FINAL;
            end else begin
               s_next.state = ST_OFF;
               s_next.arm   = 1'b0;
               s_next.bkpt  = s_reg.bp_en;
            end
         end
         default: begin
            s_next.state = ST_OFF;
            s_next.arm   = 1'b0;
         end
      endcase

      // software disarm
      if (ctrl_wr && !reg_wdata_i[ARM_BIT]) begin
         s_next.state = ST_OFF;
         s_next.arm   = 1'b0;
      end
      if (ctrl_wr) begin
         s_next.bp_en = reg_wdata_i[BP_EN_BIT];
      end
      if (s_reg.arm && |(match_i & s_reg.ch_bp)) begin
         s_next.bkpt = 1'b1;
      end
      // store gate opens one cycle after arm settles
      s_next.go = s_reg.arm && s_next.arm && !force_wr && !arm_set_wr;

      // classification comes from the core; background vectors dropped
      flow_ok = flow_valid_i && !flow_bgnd_vector_i;
      dup_src = (s_reg.mode == MODE_LOOP1) && !flow_dest_i && s_reg.bg_valid
                && (flow_addr_i == s_reg.bg_addr);
      entering_final = (s_next.state == ST_FINAL) && (s_reg.state != ST_FINAL);
      if (s_reg.align == ALIGN_END) begin
         // trigger change of flow not stored
         store_window = (s_reg.state == ST_ONE || s_reg.state == ST_TWO
                         || s_reg.state == ST_THREE) && !entering_final;
      end else begin
         store_window = ((s_reg.state == ST_FINAL) || (entering_final && !force_wr))
                        && (s_reg.count < DEPTH_CNT);
      end
      store_en = s_reg.tsrc && s_reg.arm && s_reg.go && flow_ok && !bgnd_active_i
                 && !dup_src && store_window;
      // destination flag set for destinations and vectors
      store_line = {flow_dest_i || flow_vector_i, flow_vector_i, flow_addr_i};
      if (store_en) begin
         s_next.wr_ptr   = s_reg.wr_ptr + 1'b1;
         s_next.full     = s_reg.full || (s_reg.wr_ptr == LAST_PTR);
         if (s_reg.count < DEPTH_CNT) begin
            s_next.count = s_reg.count + 1'b1;
         end
         s_next.bg_addr  = flow_addr_i;
         s_next.bg_valid = 1'b1;
      end

      if (reg_wr_i) begin
         case (reg_addr_i)
            OFF_TRACE_CTL: begin
               s_next.tsrc  = reg_wdata_i[TSRC_BIT];
               s_next.mode  = reg_wdata_i[MODE_LSB +: 2];
               s_next.align = reg_wdata_i[ALIGN_BIT];
            end
            OFF_STATE_CTL1: s_next.sc[0] = reg_wdata_i[5:0];
            OFF_STATE_CTL2: s_next.sc[1] = reg_wdata_i[5:0];
            OFF_STATE_CTL3: s_next.sc[2] = reg_wdata_i[5:0];
            OFF_CHAN_CTL:   s_next.ch_bp = reg_wdata_i[CHANNELS-1:0];
            default: ;
         endcase
      end

      if (reg_rd_i) begin
         case (reg_addr_i)
            OFF_CTRL1: begin
               s_next.rdata[ARM_BIT]   = s_reg.arm;
               s_next.rdata[BP_EN_BIT] = s_reg.bp_en;
            end
            OFF_STATUS:     s_next.rdata[2:0] = s_reg.flags;
            OFF_TRACE_CTL: begin
               s_next.rdata[TSRC_BIT]       = s_reg.tsrc;
               s_next.rdata[MODE_LSB +: 2]  = s_reg.mode;
               s_next.rdata[ALIGN_BIT]      = s_reg.align;
            end
            OFF_STATE_CTL1: s_next.rdata[5:0] = s_reg.sc[0];
            OFF_STATE_CTL2: s_next.rdata[5:0] = s_reg.sc[1];
            OFF_STATE_CTL3: s_next.rdata[5:0] = s_reg.sc[2];
            OFF_CHAN_CTL:   s_next.rdata[CHANNELS-1:0] = s_reg.ch_bp;
            // armed reads give zero, pointer held
            OFF_TRACE_HI: begin
               if (!s_reg.arm) begin
                  s_next.rdata[LINE_W-DATA_W-1:0] = rd_line[LINE_W-1:DATA_W];
               end
            end
            OFF_TRACE_LO: begin
               if (!s_reg.arm) begin
                  s_next.rdata  = rd_line[DATA_W-1:0];
                  s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
               end
            end
            OFF_LINE_CNT:   s_next.rdata[CNT_W-1:0] = s_reg.count;
            default: ;
         endcase
      end

      // oldest line first once the session closes
      if (s_reg.arm && !s_next.arm) begin
         s_next.rd_ptr = s_next.full ? s_next.wr_ptr : '0;
      end
      s_next.flags = state_to_flags(s_next.state);
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_reg          <= '0;
         s_reg.state    <= ST_OFF;
         s_reg.flags    <= FLAGS_OFF;
         s_reg.mode     <= MODE_RST;
         s_reg.align    <= ALIGN_END;
         s_reg.sc       <= {3{STATE_CTL_RST}};
      end else begin
         s_reg <= s_next;
      end
   end

   // ram has no reset; contents are only trusted after a session
   always_ff @(posedge core_clk_i) begin
      if (store_en) begin
         trace_mem[s_reg.wr_ptr] <= store_line;
      end
   end

   assign reg_rdata_o   = s_reg.rdata;
   assign breakpoint_o  = s_reg.bkpt;
   assign armed_o       = s_reg.arm;
   assign state_flags_o = s_reg.flags;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   a_arm_to_one: assert property (
      s_reg.state == ST_OFF && arm_set_wr && !reg_wdata_i[FORCE_BIT]
      |=> s_reg.state == ST_ONE && state_flags_o == FLAGS_ONE && armed_o)
      else $error("arming did not enter state1");

   a_final_exit: assert property (
      s_reg.state == ST_FINAL |=> s_reg.state inside {ST_FINAL, ST_OFF})
      else $error("final state left to a non-idle state");

   a_force_trigger_bit_final: assert property (
      s_reg.state inside {ST_ONE, ST_TWO, ST_THREE} && force_wr
      |=> s_reg.state == ST_FINAL)
      else $error("force trigger did not reach final");

   a_chan_brk: assert property (
      s_reg.arm && |(match_i & s_reg.ch_bp) |=> breakpoint_o)
      else $error("channel breakpoint missing");

   a_final_one_cycle: assert property (
      s_reg.state == ST_FINAL && !begin_trace && !$past(s_reg.state == ST_FINAL)
      |=> s_reg.state == ST_OFF && !armed_o && breakpoint_o == $past(s_reg.bp_en))
      else $error("final state not exactly one cycle");

   a_count_incr: assert property (
      store_en && s_reg.count < DEPTH_CNT |=> s_reg.count == $past(s_reg.count) + 1'b1)
      else $error("line count did not follow store");

   a_bgnd_nostore: assert property (
      bgnd_active_i |-> !store_en)
      else $error("store during background debug");

   a_armed_read_hold: assert property (
      s_reg.arm && reg_rd_i && reg_addr_i == OFF_TRACE_LO && s_next.arm
      |=> s_reg.rd_ptr == $past(s_reg.rd_ptr) && reg_rdata_o == '0)
      else $error("armed trace read moved pointer");

   a_store_delay: assert property (
      s_reg.state == ST_OFF && arm_set_wr |=> !store_en)
      else $error("store in first cycle after arming");

   a_begin_nostore: assert property (
      s_reg.align == ALIGN_BEGIN && s_reg.state != ST_FINAL && !entering_final
      |-> !store_en)
      else $error("begin alignment stored before final");

   a_loop_dup: assert property (
      dup_src |-> !store_en)
      else $error("duplicate source stored in loop mode");
endmodule

/* File: pkg/dst_pkg.sv */
package dst_pkg;
   localparam int          ADDR_W        = 4;
   localparam int          DATA_W        = 16;
   localparam int          LINE_W        = 20;
   localparam int          TRACE_LINES   = 64;
   localparam int          ADDR_BITS     = 18;
   localparam int          CHANNELS      = 3;
   // register offsets
   localparam logic [3:0]  OFF_CTRL1     = 4'h0;
   localparam logic [3:0]  OFF_STATUS    = 4'h1;
   localparam logic [3:0]  OFF_TRACE_CTL = 4'h2;
   localparam logic [3:0]  OFF_STATE_CTL1 = 4'h3;
   localparam logic [3:0]  OFF_STATE_CTL2 = 4'h4;
   localparam logic [3:0]  OFF_STATE_CTL3 = 4'h5;
   localparam logic [3:0]  OFF_CHAN_CTL  = 4'h6;
   localparam logic [3:0]  OFF_TRACE_HI  = 4'h7;
   localparam logic [3:0]  OFF_TRACE_LO  = 4'h8;
   localparam logic [3:0]  OFF_LINE_CNT  = 4'h9;
   // control one fields
   localparam int          ARM_BIT       = 7;
   localparam int          FORCE_BIT     = 6;
   localparam int          BP_EN_BIT     = 4;
   // trace control fields
   localparam int          TSRC_BIT      = 6;
   localparam int          MODE_LSB      = 2;
   localparam int          ALIGN_BIT     = 0;
   localparam logic        ALIGN_END     = 1'b0;
   localparam logic        ALIGN_BEGIN   = 1'b1;
   localparam logic [1:0]  MODE_NORMAL   = 2'h0;
   localparam logic [1:0]  MODE_LOOP1    = 2'h1;
   localparam logic [1:0]  MODE_DETAIL   = 2'h2;
   localparam logic [1:0]  MODE_PURE_PC  = 2'h3;
   // next-state codes per channel in a state control register
   localparam logic [1:0]  NXT_FINAL     = 2'h0;
   localparam logic [1:0]  NXT_ONE       = 2'h1;
   localparam logic [1:0]  NXT_TWO       = 2'h2;
   localparam logic [1:0]  NXT_THREE     = 2'h3;
   // current state flag codes
   localparam logic [2:0]  FLAGS_OFF     = 3'h0;
   localparam logic [2:0]  FLAGS_ONE     = 3'h1;
   localparam logic [2:0]  FLAGS_TWO     = 3'h2;
   localparam logic [2:0]  FLAGS_THREE   = 3'h3;
   localparam logic [2:0]  FLAGS_FINAL   = 3'h4;
   // reset values
   localparam logic [5:0]  STATE_CTL_RST = 6'h00;
   localparam logic [1:0]  MODE_RST      = 2'h0;

   typedef enum logic [2:0] {ST_OFF, ST_ONE, ST_TWO, ST_THREE, ST_FINAL} dst_state_type;
endpackage

/* File: tb/dst_core_model.sv */
`timescale 1ns/1ps
module dst_core_model (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        go_i,
   input  wire logic [4:0]  n_i,
   input  wire logic [1:0]  kind_i,
   input  wire logic [17:0] base_i,
   output logic             flow_valid_o,
   output logic [17:0]      flow_addr_o,
   output logic             flow_dest_o,
   output logic             flow_vector_o,
   output logic             flow_bgnd_vector_o,
   output logic             busy_o
);
   logic [4:0] idx_reg;
   // kind: 0 source, 1 destination, 2 vector (odd ones background), 3 same source
   // one completed flow change a cycle
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         idx_reg <= 5'h00;
         busy_o <= 1'b0;
         flow_valid_o <= 1'b0;
         flow_addr_o <= 18'h00000;
         flow_dest_o <= 1'b0;
         flow_vector_o <= 1'b0;
         flow_bgnd_vector_o <= 1'b0;
      end else begin
         flow_valid_o <= 1'b0;
         // idle address toggles so a stale value is never stored by luck
         flow_addr_o <= ~flow_addr_o;
         if (go_i) begin
            busy_o <= 1'b1;
            idx_reg <= 5'h00;
         end else if (busy_o) begin
            flow_valid_o <= 1'b1;
            flow_addr_o <= base_i + ((kind_i == 2'h3) ? 18'h00000 : 18'(idx_reg));
            flow_dest_o <= (kind_i == 2'h1) || (kind_i == 2'h2);
            flow_vector_o <= (kind_i == 2'h2);
            flow_bgnd_vector_o <= (kind_i == 2'h2) && idx_reg[0];
            idx_reg <= idx_reg + 5'h01;
            busy_o <= (idx_reg + 5'h01) != n_i;
         end
      end
   end
endmodule

/* File: tb/dst_debug_trace_tb_top.sv */
`timescale 1ns/1ps
module dst_debug_trace_tb_top;
   import dst_pkg::*;
   localparam int DEPTH = 16;
   localparam int LIMIT = 20000;
   logic        core_clk_i;
   logic        reset_i;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [2:0]  match;
   logic        bgnd_active;
   logic        flow_valid;
   logic [17:0] flow_addr;
   logic        flow_dest;
   logic        flow_vector;
   logic        flow_bgnd_vector;
   logic        breakpoint;
   logic        armed;
   logic [2:0]  state_flags;
   logic        go;
   logic [4:0]  n_ev;
   logic [1:0]  kind;
   logic [17:0] base;
   logic        busy;
   logic [15:0] v;
   logic [19:0] exp_q[$];
   int          failures = 0;
   int          n_compared = 0;
   int          bp_seen = 0;
   int          cyc = 0;
   int          b;

   dst_debug_trace #(.TRACE_DEPTH(DEPTH)) u_dst_debug_trace (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .match_i(match), .bgnd_active_i(bgnd_active),
      .flow_valid_i(flow_valid), .flow_addr_i(flow_addr), .flow_dest_i(flow_dest),
      .flow_vector_i(flow_vector), .flow_bgnd_vector_i(flow_bgnd_vector),
      .breakpoint_o(breakpoint), .armed_o(armed), .state_flags_o(state_flags));
   dst_core_model u_dst_core_model (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .go_i(go), .n_i(n_ev),
      .kind_i(kind), .base_i(base), .flow_valid_o(flow_valid), .flow_addr_o(flow_addr),
      .flow_dest_o(flow_dest), .flow_vector_o(flow_vector),
      .flow_bgnd_vector_o(flow_bgnd_vector), .busy_o(busy));

   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // counts pulses; also cuts a hang short
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (breakpoint === 1'b1) begin
         bp_seen <= bp_seen + 1;
      end
      if (cyc == LIMIT) begin
         failures = failures + 1;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk_i);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk_i);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic mt(input logic [2:0] m);
      @(posedge core_clk_i);
      match <= m;
      @(posedge core_clk_i);
      match <= 3'h0;
      #1;
   endtask
   // one flow change sampled in the same cycle as a channel 0 match
   task automatic hit(input logic [17:0] a);
      @(posedge core_clk_i);
      n_ev <= 5'h01;
      kind <= 2'h0;
      base <= a;
      go <= 1'b1;
      @(posedge core_clk_i);
      go <= 1'b0;
      @(posedge core_clk_i);
      match <= 3'b001;
      @(posedge core_clk_i);
      match <= 3'h0;
      #1;
   endtask
   task automatic burst(input logic [4:0] n, input logic [1:0] k, input logic [17:0] a);
      @(posedge core_clk_i);
      n_ev <= n;
      kind <= k;
      base <= a;
      go <= 1'b1;
      @(posedge core_clk_i);
      go <= 1'b0;
      #1;
      while (busy === 1'b1) begin
         @(posedge core_clk_i);
         #1;
      end
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask
   task automatic fin(input int bp_exp);
      int b0;
      b0 = bp_seen;
      chk("flags in final", 20'(FLAGS_FINAL), 20'(state_flags));
      @(posedge core_clk_i);
      #1;
      chk("flags after final", 20'(FLAGS_OFF), 20'(state_flags));
      chk("armed after final", 20'h0, 20'(armed));
      @(posedge core_clk_i);
      #1;
      chk("session breakpoint", 20'(b0 + bp_exp), 20'(bp_seen));
   endtask
   task automatic ex(input logic [17:0] a, input logic d, input logic vc, input int n, input int s);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back({d, vc, 18'(a + 18'(i * s))});
      end
   endtask
   task automatic drain(input int n, input bit cc);
      logic [15:0] h;
      logic [15:0] l;
      if (cc) begin
         rd(OFF_LINE_CNT, l);
         chk("line count", 20'(n), 20'(l));
      end
      // high half first, low half moves the pointer
      repeat (n) begin
         rd(OFF_TRACE_HI, h);
         rd(OFF_TRACE_LO, l);
         chk("trace line", exp_q.pop_front(), {h[3:0], l});
      end
   endtask

   initial begin
      reset_i = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      match = 3'h0;
      bgnd_active = 1'b0;
      go = 1'b0;
      n_ev = 5'h01;
      kind = 2'h0;
      base = 18'h00000;
      repeat (20) @(posedge core_clk_i);
      reset_i <= 1'b0;
      #1;
      for (int a = 0; a < 16; a++) begin
         if (a != 7 && a != 8) begin
            rd(4'(a), v);
            chk("reset register", 20'h0, 20'(v));
         end
      end
      note("reset");
      wr(OFF_STATE_CTL1, 16'h0032);
      wr(OFF_STATE_CTL2, 16'h000e);
      wr(OFF_STATE_CTL3, 16'h000d);
      rd(OFF_STATE_CTL1, v);
      chk("state control", 20'h00032, 20'(v));
      wr(OFF_CTRL1, 16'h0090);
      rd(OFF_STATUS, v);
      chk("status after arm", 20'(FLAGS_ONE), 20'(v));
      mt(3'b101);
      chk("lowest channel wins", 20'(FLAGS_TWO), 20'(state_flags));
      mt(3'b010);
      chk("state three", 20'(FLAGS_THREE), 20'(state_flags));
      mt(3'b001);
      chk("back to one", 20'(FLAGS_ONE), 20'(state_flags));
      mt(3'b011);
      fin(1);
      wr(OFF_CHAN_CTL, 16'h0004);
      wr(OFF_CTRL1, 16'h0080);
      b = bp_seen;
      mt(3'b100);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("channel breakpoint", 20'(b + 1), 20'(bp_seen));
      chk("flags kept", 20'(FLAGS_ONE), 20'(state_flags));
      mt(3'b001);
      chk("other channel moves", 20'(FLAGS_TWO), 20'(state_flags));
      wr(OFF_CHAN_CTL, 16'h0000);
      wr(OFF_CTRL1, 16'h0000);
      chk("disarm write", 20'(FLAGS_OFF), 20'(state_flags));
      note("sequencer");
      wr(OFF_STATE_CTL1, 16'h0000);
      wr(OFF_TRACE_CTL, 16'h0040);
      wr(OFF_CTRL1, 16'h0080);
      @(posedge core_clk_i);
      bgnd_active <= 1'b1;
      burst(5'd2, 2'd0, 18'h00010);
      @(posedge core_clk_i);
      bgnd_active <= 1'b0;
      burst(5'd2, 2'd0, 18'h00100);
      burst(5'd4, 2'd2, 18'h00200);
      burst(5'd2, 2'd1, 18'h00300);
      rd(OFF_TRACE_LO, v);
      chk("armed window read", 20'h0, 20'(v));
      hit(18'h00390);
      fin(0);
      ex(18'h00100, 1'b0, 1'b0, 2, 1);
      ex(18'h00200, 1'b1, 1'b1, 2, 2);
      ex(18'h00300, 1'b1, 1'b0, 2, 1);
      drain(6, 1'b1);
      note("end alignment");
      wr(OFF_TRACE_CTL, 16'h0048);
      wr(OFF_CTRL1, 16'h0080);
      burst(5'(DEPTH + 2), 2'd0, 18'h00600);
      mt(3'b001);
      fin(0);
      ex(18'h00602, 1'b0, 1'b0, DEPTH, 1);
      drain(DEPTH, 1'b0);
      note("wrap");
      wr(OFF_TRACE_CTL, 16'h0044);
      wr(OFF_CTRL1, 16'h0080);
      burst(5'd4, 2'd3, 18'h00700);
      burst(5'd1, 2'd1, 18'h00700);
      burst(5'd1, 2'd1, 18'h00700);
      burst(5'd3, 2'd3, 18'h00710);
      mt(3'b001);
      fin(0);
      ex(18'h00700, 1'b0, 1'b0, 1, 0);
      ex(18'h00700, 1'b1, 1'b0, 2, 0);
      ex(18'h00710, 1'b0, 1'b0, 1, 0);
      drain(4, 1'b1);
      note("loop1");
      wr(OFF_TRACE_CTL, 16'h004d);
      wr(OFF_CTRL1, 16'h0090);
      burst(5'd2, 2'd0, 18'h00400);
      b = bp_seen;
      wr(OFF_CTRL1, 16'h00d0);
      chk("forced final", 20'(FLAGS_FINAL), 20'(state_flags));
      burst(5'(DEPTH), 2'd1, 18'h00500);
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("armed after fill", 20'h0, 20'(armed));
      chk("flags after fill", 20'(FLAGS_OFF), 20'(state_flags));
      chk("fill breakpoint", 20'(b + 1), 20'(bp_seen));
      ex(18'h00500, 1'b1, 1'b0, DEPTH, 1);
      drain(DEPTH, 1'b1);
      // channel trigger that coincides with a flow change keeps it as line one
      wr(OFF_CTRL1, 16'h0080);
      hit(18'h00800);
      burst(5'(DEPTH - 1), 2'h1, 18'h00801);
      chk("armed after trigger fill", 20'h0, 20'(armed));
      ex(18'h00800, 1'b0, 1'b0, 1, 0);
      ex(18'h00801, 1'b1, 1'b0, DEPTH - 1, 1);
      drain(DEPTH, 1'b1);
      note("begin alignment");
      wrap_up();
   end
endmodule
